// >>> pkg/tfoc_defs.vh
/*
 Register map, field positions and reset values of the thermal fan override block.
 Assumes inclusion by bare name from the core files.
*/
`ifndef TFOC_DEFS_VH
`define TFOC_DEFS_VH

`define TFOC_AW 8
`define TFOC_DW 8

`define TFOC_A_OP_R1 8'h33
`define TFOC_A_OP_LOC 8'h34
`define TFOC_A_OP_R2 8'h35
`define TFOC_A_ACOUSTIC 8'h62
`define TFOC_A_CRIT_R1 8'h6a
`define TFOC_A_CRIT_LOC 8'h6b
`define TFOC_A_CRIT_R2 8'h6c
`define TFOC_A_HYST_RL 8'h6d
`define TFOC_A_HYST_R2 8'h6e
`define TFOC_A_START_R1 8'h80
`define TFOC_A_START_LOC 8'h81
`define TFOC_A_START_R2 8'h82
`define TFOC_A_STATUS 8'h83
`define TFOC_A_MASK 8'h84
`define TFOC_A_CONFIG 8'h85
`define TFOC_A_STATE 8'h86

`define TFOC_OP_RST 8'ha4
`define TFOC_CRIT_RST 8'ha4
`define TFOC_HYST_RL_RST 8'h44
`define TFOC_HYST_R2_RST 8'h40
`define TFOC_HYST_R2_MASK 8'hf0
`define TFOC_ACOUSTIC_RST 8'h00
`define TFOC_START_RST 8'h5a
`define TFOC_CONFIG_RST 8'h00
`define TFOC_STATUS_RST 3'h0
`define TFOC_MASK_RST 3'h0

`define TFOC_KEEP_LSB 5
`define TFOC_KEEP_MSB 7
`define TFOC_HYST_HI_MSB 7
`define TFOC_HYST_HI_LSB 4
`define TFOC_HYST_LO_MSB 3
`define TFOC_HYST_LO_LSB 0
`define TFOC_CFG_DYN_EN 0

`define TFOC_DUTY_FULL 8'hff
`define TFOC_DUTY_OFF 8'h00
`define TFOC_TEMP_MAX 8'hff
`define TFOC_TEMP_MIN 8'h00
`define TFOC_STEP 8'h01

`endif

// >>> core/tfoc_chan.v
/*
 One temperature channel: critical override latch with hysteresis, fan on/off
 hysteresis around the start temperature and dynamic start temperature tracking.
 Assumes temperature codes arrive on the system clock with a one-cycle valid pulse.
*/
`timescale 1ns/1ps
`include "tfoc_defs.vh"

module tfoc_chan (
    input wire i_clk,
    input wire i_rstn,
    input wire [7:0] i_temp,
    input wire i_valid,
    input wire [7:0] i_crit_limit,
    input wire [7:0] i_op_point,
    input wire [3:0] i_hyst,
    input wire i_dyn_en,
    input wire i_start_wr,
    input wire [7:0] i_start_wdata,
    output wire o_crit,
    output wire o_crit_set,
    output wire o_above_start,
    output wire o_fan_on,
    output wire [7:0] o_start_temp
);
    reg crit_q;
    reg crit_d;
    reg crit_set_q;
    reg above_q;
    reg on_q;
    reg on_d;
    reg [7:0] start_q;
    reg [7:0] start_d;
    wire [7:0] crit_rel;
    wire [7:0] start_rel;
    wire [7:0] op_rel;

    // Saturating subtraction of the hysteresis
    function [7:0] sat_sub;
        input [7:0] a;
        input [3:0] h;
        reg [8:0] diff;
        begin
            diff = {1'b0, a} - {5'h00, h};
            sat_sub = diff[8] ? `TFOC_TEMP_MIN : diff[7:0];
        end
    endfunction

    assign crit_rel = sat_sub(i_crit_limit, i_hyst);
    assign start_rel = sat_sub(start_q, i_hyst);
    assign op_rel = sat_sub(i_op_point, i_hyst);

    always @* begin
        crit_d = crit_q;
        on_d = on_q;
        start_d = start_q;
        if (i_valid) begin
            if (i_temp > i_crit_limit) begin
                crit_d = 1'b1;
            end else if (i_temp < crit_rel) begin
                crit_d = 1'b0;
            end
            if (i_temp > start_q) begin
                on_d = 1'b1;
            end else if (i_temp < start_rel) begin
                on_d = 1'b0;
            end
            if (i_dyn_en) begin
                if (i_temp > i_op_point && start_q != `TFOC_TEMP_MIN) begin
                    start_d = start_q - `TFOC_STEP;
                end else if (i_temp < op_rel && start_q != `TFOC_TEMP_MAX) begin
                    start_d = start_q + `TFOC_STEP;
                end
            end
        end
        if (i_start_wr) begin
            start_d = i_start_wdata;
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            crit_q <= 1'b0;
            crit_set_q <= 1'b0;
            above_q <= 1'b0;
            on_q <= 1'b0;
            start_q <= `TFOC_START_RST;
        end else begin
            crit_q <= crit_d;
            crit_set_q <= crit_d & ~crit_q;
            if (i_valid) begin
                above_q <= (i_temp > start_q);
            end
            on_q <= on_d;
            start_q <= start_d;
        end
    end

    assign o_crit = crit_q;
    assign o_crit_set = crit_set_q;
    assign o_above_start = above_q;
    assign o_fan_on = on_q;
    assign o_start_temp = start_q;
endmodule

// >>> core/tfoc_top.v
/*
 Thermal fan override controller: register file, three channels, override of the
 three fan drive duties and a maskable interrupt on critical events.
 Assumes temperature codes and automatic/floor duties come from logic on I_CLOCK.
*/
// Notes on behaviour
// - Any channel above its critical limit forces all fan outputs to full duty.
// - Full duty holds until that channel drops below limit minus its hysteresis.
// - The critical override ignores every automatic control setting; no mask.
// - Three critical limit registers, each resetting to code a4.
// - Hysteresis is a four-bit field, whole degrees, zero to fifteen.
// - Remote1 in 7:4, local in 3:0, remote2 in 7:4 of second; default four.
// - Fan keeps running until temperature drops below start minus hysteresis.
// - One hysteresis field serves fan on/off and critical release.
// - Acoustics bits 7,6,5 pick off or floor duty for outputs 3,2,1.
// - With floor duty kept, hysteresis has no effect below start temperature.
// - Three eight-bit operating point registers resetting to a4.
// - Start temperature rises below target minus hysteresis and falls when target is exceeded.
// - Full duty is code 255.
`timescale 1ns/1ps
`include "tfoc_defs.vh"

module tfoc_top #(
    parameter NCH = 3
) (
    input wire I_CLOCK,
    input wire I_RSTN,
    input wire [`TFOC_AW-1:0] I_ADDR,
    input wire [`TFOC_DW-1:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [`TFOC_DW-1:0] O_RDATA,
    input wire [7:0] I_TEMP_R1,
    input wire [7:0] I_TEMP_LOC,
    input wire [7:0] I_TEMP_R2,
    input wire I_TEMP_VALID,
    input wire [7:0] I_AUTO_DUTY1,
    input wire [7:0] I_AUTO_DUTY2,
    input wire [7:0] I_AUTO_DUTY3,
    input wire [7:0] I_FLOOR_DUTY1,
    input wire [7:0] I_FLOOR_DUTY2,
    input wire [7:0] I_FLOOR_DUTY3,
    output reg [7:0] O_FAN_DRIVE_OUT1,
    output reg [7:0] O_FAN_DRIVE_OUT2,
    output reg [7:0] O_FAN_DRIVE_OUT3,
    output reg O_OVERRIDE,
    output reg O_IRQ
);
    reg [7:0] op_r1_q;
    reg [7:0] op_loc_q;
    reg [7:0] op_r2_q;
    reg [7:0] crit_r1_q;
    reg [7:0] crit_loc_q;
    reg [7:0] crit_r2_q;
    reg [7:0] hyst_rl_q;
    reg [7:0] hyst_r2_q;
    reg [7:0] acoustic_q;
    reg [7:0] config_q;
    reg [2:0] status_q;
    reg [2:0] status_d;
    reg [2:0] mask_q;
    reg [7:0] rdata_d;
    reg [7:0] drive_d [0:2];

    wire [8*NCH-1:0] temp_bus;
    wire [8*NCH-1:0] crit_bus;
    wire [8*NCH-1:0] op_bus;
    wire [4*NCH-1:0] hyst_bus;
    wire [8*NCH-1:0] start_bus;
    wire [8*NCH-1:0] auto_bus;
    wire [8*NCH-1:0] floor_bus;
    wire [NCH-1:0] start_wr;
    wire [NCH-1:0] crit_on;
    wire [NCH-1:0] crit_set;
    wire [NCH-1:0] above;
    wire [NCH-1:0] fan_on;
    wire [2:0] keep_spin;
    wire any_crit;

    // Write strobe decode
    function wr_hit;
        input wr;
        input [7:0] addr;
        input [7:0] target;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    assign temp_bus = {I_TEMP_R2, I_TEMP_LOC, I_TEMP_R1};
    assign crit_bus = {crit_r2_q, crit_loc_q, crit_r1_q};
    assign op_bus = {op_r2_q, op_loc_q, op_r1_q};
    assign hyst_bus = {hyst_r2_q[`TFOC_HYST_HI_MSB:`TFOC_HYST_HI_LSB],
                       hyst_rl_q[`TFOC_HYST_LO_MSB:`TFOC_HYST_LO_LSB],
                       hyst_rl_q[`TFOC_HYST_HI_MSB:`TFOC_HYST_HI_LSB]};
    assign auto_bus = {I_AUTO_DUTY3, I_AUTO_DUTY2, I_AUTO_DUTY1};
    assign floor_bus = {I_FLOOR_DUTY3, I_FLOOR_DUTY2, I_FLOOR_DUTY1};
    assign start_wr = {wr_hit(I_WR, I_ADDR, `TFOC_A_START_R2),
                       wr_hit(I_WR, I_ADDR, `TFOC_A_START_LOC),
                       wr_hit(I_WR, I_ADDR, `TFOC_A_START_R1)};
    // Bit 5 is output 1, bit 7 is output 3
    assign keep_spin = acoustic_q[`TFOC_KEEP_MSB:`TFOC_KEEP_LSB];
    assign any_crit = |crit_on;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_chan
            tfoc_chan u_chan (
                .i_clk(I_CLOCK),
                .i_rstn(I_RSTN),
                .i_temp(temp_bus[8*g+7:8*g]),
                .i_valid(I_TEMP_VALID),
                .i_crit_limit(crit_bus[8*g+7:8*g]),
                .i_op_point(op_bus[8*g+7:8*g]),
                .i_hyst(hyst_bus[4*g+3:4*g]),
                .i_dyn_en(config_q[`TFOC_CFG_DYN_EN]),
                .i_start_wr(start_wr[g]),
                .i_start_wdata(I_WDATA),
                .o_crit(crit_on[g]),
                .o_crit_set(crit_set[g]),
                .o_above_start(above[g]),
                .o_fan_on(fan_on[g]),
                .o_start_temp(start_bus[8*g+7:8*g])
            );
        end
    endgenerate

    // Output n follows channel n
    integer k;
    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            if (any_crit) begin
                drive_d[k] = `TFOC_DUTY_FULL;
            end else if (above[k]) begin
                drive_d[k] = auto_bus[8*k+7 -: 8];
            end else if (keep_spin[k]) begin
                drive_d[k] = floor_bus[8*k+7 -: 8];
            end else if (fan_on[k]) begin
                drive_d[k] = floor_bus[8*k+7 -: 8];
            end else begin
                drive_d[k] = `TFOC_DUTY_OFF;
            end
        end
    end

    // Set wins over write-one-to-clear
    always @* begin
        status_d = status_q;
        if (wr_hit(I_WR, I_ADDR, `TFOC_A_STATUS)) begin
            status_d = status_q & ~I_WDATA[2:0];
        end
        status_d = status_d | crit_set;
    end

    always @* begin
        rdata_d = 8'h00;
        if (I_RD) begin
            case (I_ADDR)
                `TFOC_A_OP_R1: rdata_d = op_r1_q;
                `TFOC_A_OP_LOC: rdata_d = op_loc_q;
                `TFOC_A_OP_R2: rdata_d = op_r2_q;
                `TFOC_A_ACOUSTIC: rdata_d = acoustic_q;
                `TFOC_A_CRIT_R1: rdata_d = crit_r1_q;
                `TFOC_A_CRIT_LOC: rdata_d = crit_loc_q;
                `TFOC_A_CRIT_R2: rdata_d = crit_r2_q;
                `TFOC_A_HYST_RL: rdata_d = hyst_rl_q;
                `TFOC_A_HYST_R2: rdata_d = hyst_r2_q;
                `TFOC_A_START_R1: rdata_d = start_bus[7:0];
                `TFOC_A_START_LOC: rdata_d = start_bus[15:8];
                `TFOC_A_START_R2: rdata_d = start_bus[23:16];
                `TFOC_A_STATUS: rdata_d = {5'h00, status_q};
                `TFOC_A_MASK: rdata_d = {5'h00, mask_q};
                `TFOC_A_CONFIG: rdata_d = config_q;
                `TFOC_A_STATE: rdata_d = {1'b0, fan_on, 1'b0, crit_on};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            op_r1_q <= `TFOC_OP_RST;
            op_loc_q <= `TFOC_OP_RST;
            op_r2_q <= `TFOC_OP_RST;
            crit_r1_q <= `TFOC_CRIT_RST;
            crit_loc_q <= `TFOC_CRIT_RST;
            crit_r2_q <= `TFOC_CRIT_RST;
            hyst_rl_q <= `TFOC_HYST_RL_RST;
            hyst_r2_q <= `TFOC_HYST_R2_RST;
            acoustic_q <= `TFOC_ACOUSTIC_RST;
            config_q <= `TFOC_CONFIG_RST;
            status_q <= `TFOC_STATUS_RST;
            mask_q <= `TFOC_MASK_RST;
        end else begin
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_OP_R1)) op_r1_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_OP_LOC)) op_loc_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_OP_R2)) op_r2_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_CRIT_R1)) crit_r1_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_CRIT_LOC)) crit_loc_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_CRIT_R2)) crit_r2_q <= I_WDATA;
            // Zero is accepted; it simply removes the hysteresis band
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_HYST_RL)) hyst_rl_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_HYST_R2)) begin
                hyst_r2_q <= I_WDATA & `TFOC_HYST_R2_MASK;
            end
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_ACOUSTIC)) acoustic_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_CONFIG)) config_q <= I_WDATA;
            if (wr_hit(I_WR, I_ADDR, `TFOC_A_MASK)) mask_q <= I_WDATA[2:0];
            status_q <= status_d;
        end
    end

    always @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RDATA <= 8'h00;
            O_FAN_DRIVE_OUT1 <= `TFOC_DUTY_OFF;
            O_FAN_DRIVE_OUT2 <= `TFOC_DUTY_OFF;
            O_FAN_DRIVE_OUT3 <= `TFOC_DUTY_OFF;
            O_OVERRIDE <= 1'b0;
            O_IRQ <= 1'b0;
        end else begin
            O_RDATA <= rdata_d;
            O_FAN_DRIVE_OUT1 <= drive_d[0];
            O_FAN_DRIVE_OUT2 <= drive_d[1];
            O_FAN_DRIVE_OUT3 <= drive_d[2];
            O_OVERRIDE <= any_crit;
            O_IRQ <= |(status_d & mask_q);
        end
    end
endmodule

// >>> tb/tfoc_fan_model.sv
/* Fan on one drive output: offers its floor duty, reports spinning.
 Assumes the duty code is sampled on the system clock. */
`timescale 1ns/1ps
module tfoc_fan_model #(
    parameter FLOOR = 8'h20
) (
    input wire i_clk,
    input wire [7:0] i_duty,
    output wire [7:0] o_floor,
    output reg o_spinning
);
    assign o_floor = FLOOR;
    initial o_spinning = 1'b0;
    always @(posedge i_clk) begin
        o_spinning <= i_duty != 8'h00;
    end
endmodule

// >>> tb/tfoc_top_assertions.sv
/* Checker of the override block with a shadow of limits and latches.
 Assumes bind into tfoc_top, one clock domain. */
`timescale 1ns/1ps
`include "tfoc_defs.vh"
module tfoc_checker #(
    parameter NCH = 3
) (
    input wire I_CLOCK,
    input wire I_RSTN,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire [7:0] O_RDATA,
    input wire [7:0] I_TEMP_R1,
    input wire [7:0] I_TEMP_LOC,
    input wire [7:0] I_TEMP_R2,
    input wire I_TEMP_VALID,
    input wire [7:0] O_FAN_DRIVE_OUT1,
    input wire [7:0] O_FAN_DRIVE_OUT2,
    input wire [7:0] O_FAN_DRIVE_OUT3,
    input wire O_OVERRIDE,
    input wire O_IRQ
);
    wire [7:0] tp [0:2];
    reg [7:0] lim_q [0:2];
    reg [3:0] hy_q [0:2];
    reg [2:0] lat_q;
    integer k;
    assign tp[0] = I_TEMP_R1;
    assign tp[1] = I_TEMP_LOC;
    assign tp[2] = I_TEMP_R2;
    always @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (k = 0; k < 3; k = k + 1) begin
                lim_q[k] <= `TFOC_CRIT_RST;
                hy_q[k] <= 4'h4;
            end
            lat_q <= 3'h0;
        end else begin
            for (k = 0; k < 3; k = k + 1) begin
                if (I_WR && I_ADDR == `TFOC_A_CRIT_R1 + k[7:0])
                    lim_q[k] <= I_WDATA;
                if (I_TEMP_VALID && tp[k] > lim_q[k])
                    lat_q[k] <= 1'b1;
                else if (I_TEMP_VALID && {1'b0, tp[k]} + hy_q[k] < {1'b0, lim_q[k]})
                    lat_q[k] <= 1'b0;
            end
            if (I_WR && I_ADDR == `TFOC_A_HYST_RL) begin
                hy_q[0] <= I_WDATA[7:4];
                hy_q[1] <= I_WDATA[3:0];
            end
            if (I_WR && I_ADDR == `TFOC_A_HYST_R2)
                hy_q[2] <= I_WDATA[7:4];
        end
    end
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RSTN);
    sequence rd_crit_s;
        I_RD && I_ADDR == `TFOC_A_CRIT_R1;
    endsequence
    sequence rd_hyst_s;
        I_RD && I_ADDR == `TFOC_A_HYST_RL;
    endsequence
    a_override_tracks: assert property (O_OVERRIDE == $past(|lat_q))
        else $error("override differs from limit model");
    a_override_full: assert property (O_OVERRIDE |->
        {O_FAN_DRIVE_OUT1, O_FAN_DRIVE_OUT2, O_FAN_DRIVE_OUT3} == 24'hffffff)
        else $error("override without full duty");
    a_rise_after_sample: assert property ($rose(O_OVERRIDE) |-> $past(I_TEMP_VALID, 2))
        else $error("override rose without sample");
    a_fall_after_sample: assert property ($fell(O_OVERRIDE) |-> $past(I_TEMP_VALID, 2))
        else $error("override fell without sample");
    a_rdata_idle_zero: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside read slot");
    a_limit_readback: assert property (rd_crit_s |=> O_RDATA == $past(lim_q[0]))
        else $error("limit readback wrong");
    a_hyst_readback: assert property (rd_hyst_s |=>
        O_RDATA == {$past(hy_q[0]), $past(hy_q[1])})
        else $error("hysteresis readback wrong");
    a_irq_has_cause: assert property ($rose(O_IRQ) |->
        $past(I_TEMP_VALID, 2) || $past(I_WR) || $past(I_WR, 2))
        else $error("interrupt rose without cause");
endmodule
bind tfoc_top tfoc_checker #(.NCH(NCH)) chk_u (
    .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_TEMP_R1(I_TEMP_R1),
    .I_TEMP_LOC(I_TEMP_LOC), .I_TEMP_R2(I_TEMP_R2), .I_TEMP_VALID(I_TEMP_VALID),
    .O_FAN_DRIVE_OUT1(O_FAN_DRIVE_OUT1), .O_FAN_DRIVE_OUT2(O_FAN_DRIVE_OUT2),
    .O_FAN_DRIVE_OUT3(O_FAN_DRIVE_OUT3), .O_OVERRIDE(O_OVERRIDE), .O_IRQ(O_IRQ)
);

// >>> tb/thermal_fan_override_ctrl_test.sv
/* Self-checking bench: register bus tasks, temperature samples, three fans.
 Assumes tfoc_top, the fan model and the checker are compiled first. */
`timescale 1ns/1ps
`include "tfoc_defs.vh"
module thermal_fan_override_ctrl_test;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] t_r1 = 8'h30;
    reg [7:0] t_loc = 8'h30;
    reg [7:0] t_r2 = 8'h30;
    reg vld = 1'b0;
    reg [7:0] auto_d = 8'h40;
    reg [7:0] v;
    reg [7:0] lim;
    wire [7:0] rdata, d1, d2, d3, f1, f2, f3;
    wire ovr, irq, spin1;
    integer errors = 0;
    integer compares = 0;
    integer i;
    tfoc_top #(.NCH(3)) dut_u (
        .I_CLOCK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_TEMP_R1(t_r1), .I_TEMP_LOC(t_loc),
        .I_TEMP_R2(t_r2), .I_TEMP_VALID(vld), .I_AUTO_DUTY1(auto_d),
        .I_AUTO_DUTY2(auto_d + 8'h01), .I_AUTO_DUTY3(auto_d + 8'h02),
        .I_FLOOR_DUTY1(f1), .I_FLOOR_DUTY2(f2), .I_FLOOR_DUTY3(f3),
        .O_FAN_DRIVE_OUT1(d1), .O_FAN_DRIVE_OUT2(d2), .O_FAN_DRIVE_OUT3(d3),
        .O_OVERRIDE(ovr), .O_IRQ(irq)
    );
    tfoc_fan_model #(.FLOOR(8'h20)) fan1_u (.i_clk(clk), .i_duty(d1), .o_floor(f1), .o_spinning(spin1));
    tfoc_fan_model #(.FLOOR(8'h28)) fan2_u (.i_clk(clk), .i_duty(d2), .o_floor(f2), .o_spinning());
    tfoc_fan_model #(.FLOOR(8'h30)) fan3_u (.i_clk(clk), .i_duty(d3), .o_floor(f3), .o_spinning());
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            chk(rdata, exp);
        end
    endtask
    task temp(input [7:0] a, input [7:0] b);
        begin
            @(posedge clk);
            t_r1 <= a;
            t_loc <= b;
            vld <= 1'b1;
            @(posedge clk);
            vld <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task final_report;
        begin
            $display("compares=%0d errors=%0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        errors = errors + 1;
        final_report;
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            rchk(`TFOC_A_OP_R1 + i[7:0], 8'ha4);
            rchk(`TFOC_A_CRIT_R1 + i[7:0], 8'ha4);
        end
        rchk(`TFOC_A_HYST_RL, 8'h44);
        rchk(`TFOC_A_HYST_R2, 8'h40);
        rchk(8'h10, 8'h00);
        $display("test reset_values done");
        wreg(`TFOC_A_HYST_R2, 8'hff);
        rchk(`TFOC_A_HYST_R2, 8'hf0);
        lim = 8'h50;
        wreg(`TFOC_A_CRIT_R1, lim);
        rchk(`TFOC_A_CRIT_R1, lim);
        wreg(`TFOC_A_MASK, 8'h07);
        temp(8'h30, 8'h30);
        chk(d1, 8'h00);
        for (i = 0; i < 2; i = i + 1) begin
            v = (i == 0) ? 8'h01 : 8'h04;
            wreg(`TFOC_A_HYST_RL, {v[3:0], 4'h4});
            temp(lim + 8'h01, 8'h30);
            chk(d1, 8'hff);
            chk(d3, 8'hff);
            chk(irq, 1'b1);
            chk(ovr, 1'b1);
            temp(lim - v, 8'h30);
            chk(d2, 8'hff);
            temp(lim - v - 8'h01, 8'h30);
            chk(d2, 8'h00);
            chk(ovr, 1'b0);
            wreg(`TFOC_A_STATUS, 8'h01);
            temp(8'h30, 8'h30);
            chk(irq, 1'b0);
        end
        wreg(`TFOC_A_CRIT_R1, 8'ha4);
        wreg(`TFOC_A_ACOUSTIC, 8'he0);
        temp(8'h30, 8'ha5);
        chk(d1, 8'hff);
        rchk(`TFOC_A_STATE, 8'h22);
        rchk(`TFOC_A_STATUS, 8'h02);
        temp(8'h30, 8'h30);
        chk(d1, 8'h20);
        chk(d2, 8'h28);
        chk(d3, 8'h30);
        wreg(`TFOC_A_ACOUSTIC, 8'h00);
        $display("test override done");
        temp(8'h5b, 8'h30);
        chk(d1, 8'h40);
        temp(8'h56, 8'h30);
        chk(d1, 8'h20);
        temp(8'h55, 8'h30);
        chk(d1, 8'h00);
        chk(spin1, 1'b0);
        wreg(`TFOC_A_ACOUSTIC, 8'h20);
        temp(8'h55, 8'h30);
        chk(d1, 8'h20);
        wreg(`TFOC_A_ACOUSTIC, 8'h00);
        $display("test fan_hysteresis done");
        wreg(`TFOC_A_OP_R1, 8'h50);
        wreg(`TFOC_A_CONFIG, 8'h01);
        temp(8'h60, 8'h30);
        rchk(`TFOC_A_START_R1, 8'h59);
        temp(8'h40, 8'h30);
        temp(8'h40, 8'h30);
        rchk(`TFOC_A_START_R1, 8'h5b);
        $display("test dynamic_start done");
        final_report;
    end
endmodule
